// >>> src/stk_map.svh
`ifndef STK_MAP_SVH
`define STK_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define STK_CTRL_ADDR       32'hE000_E010
`define STK_RELOAD_ADDR     32'hE000_E014
`define STK_CURRENT_ADDR    32'hE000_E018

////////////////////////////////////////////////////////////////////////////////
// Field positions and widths
`define STK_EN_BIT          0
`define STK_IE_BIT          1
`define STK_CLKSEL_BIT      2
`define STK_FLAG_BIT        16
`define STK_CNT_WIDTH       24

////////////////////////////////////////////////////////////////////////////////
// Reset values and bus answers
`define STK_BIT_RESET       1'h0
`define STK_RELOAD_RESET    24'h00_0000
`define STK_COUNT_RESET     24'h00_0000
`define STK_RESP_OKAY       2'h0
`define STK_RESP_SLVERR     2'h2

`endif

// >>> src/stk_pkg.sv
package stk_pkg;

    typedef enum logic [1:0] {
        STK_SEL_CTRL    = 2'h0,
        STK_SEL_RELOAD  = 2'h1,
        STK_SEL_CURRENT = 2'h2,
        STK_SEL_NONE    = 2'h3
    } stk_reg_sel_type;

    typedef enum logic {
        STK_CH_IDLE = 1'h0,
        STK_CH_RESP = 1'h1
    } stk_chan_state_type;

endpackage

// >>> src/stk_down_counter.sv
`timescale 1ns/1ns
`include "stk_map.svh"

module stk_down_counter #(
    parameter int WIDTH = `STK_CNT_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] reload,
    output logic      [WIDTH-1:0] count,
    output logic                  wrap_hit
);

    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

    // Clear wins over counting, so a clearing write never looks like a wrap
    assign wrap_hit = run && !clear && (count == ONE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (run) begin
            if (count == '0) begin
                // A zero reload leaves the counter parked at zero
                count <= reload;
            end else begin
                count <= count - ONE;
            end
        end
    end

endmodule

// >>> src/stk_top.sv
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "stk_map.svh"

module stk_top
    import stk_pkg::*;
#(
    parameter int CNT_WIDTH = `STK_CNT_WIDTH
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        core_halted,
    input  wire logic        debugger_access,
    input  wire logic        debugger_master_kind,
    output logic             tick_pend
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    stk_chan_state_type     wr_state;
    stk_chan_state_type     next_wr_state;
    stk_chan_state_type     rd_state;
    stk_chan_state_type     next_rd_state;
    logic                   aw_held;
    logic                   next_aw_held;
    logic                   w_held;
    logic                   next_w_held;
    logic [31:0]            awaddr_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    logic                   aw_hs;
    logic                   w_hs;
    logic                   ar_hs;
    logic                   do_write;
    stk_reg_sel_type        wr_sel;
    stk_reg_sel_type        rd_sel;
    logic                   enable;
    logic                   tick_irq_enable;
    logic                   clock_select;
    logic                   wrap_flag;
    logic [CNT_WIDTH-1:0]   reload_val;
    logic [CNT_WIDTH-1:0]   count;
    logic                   wrap_hit;
    logic                   run;
    logic                   cur_clear;
    logic                   flag_read_clr;
    logic [31:0]            ctrl_merged;
    logic [31:0]            ctrl_word;
    logic [31:0]            reload_merged;
    logic [31:0]            rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Word compare only; the low address bits pick byte lanes through wstrb
    function automatic stk_reg_sel_type decode(input logic [31:0] addr);
        stk_reg_sel_type sel;
        sel = STK_SEL_NONE;
        if (addr[31:2] == 30'(`STK_CTRL_ADDR >> 2)) begin
            sel = STK_SEL_CTRL;
        end else if (addr[31:2] == 30'(`STK_RELOAD_ADDR >> 2)) begin
            sel = STK_SEL_RELOAD;
        end else if (addr[31:2] == 30'(`STK_CURRENT_ADDR >> 2)) begin
            sel = STK_SEL_CURRENT;
        end
        return sel;
    endfunction

    // Lane 0 is always bits 7:0, whatever order the core uses
    function automatic logic [31:0] merge(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_word[8*i +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write channel

    assign aw_hs    = s_axi_awvalid && s_axi_awready;
    assign w_hs     = s_axi_wvalid && s_axi_wready;
    assign do_write = (wr_state == STK_CH_IDLE) && aw_held && w_held;
    assign wr_sel   = decode(awaddr_q);

    always_comb begin
        next_wr_state = wr_state;
        next_aw_held  = aw_held || aw_hs;
        next_w_held   = w_held || w_hs;
        case (wr_state)
            STK_CH_IDLE: begin
                if (do_write) begin
                    next_wr_state = STK_CH_RESP;
                    next_aw_held  = 1'h0;
                    next_w_held   = 1'h0;
                end
            end
            STK_CH_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = STK_CH_IDLE;
                end
            end
            default: begin
                next_wr_state = STK_CH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state      <= STK_CH_IDLE;
            aw_held       <= 1'h0;
            w_held        <= 1'h0;
            s_axi_awready <= 1'h0;
            s_axi_wready  <= 1'h0;
            s_axi_bvalid  <= 1'h0;
            s_axi_bresp   <= `STK_RESP_OKAY;
        end else begin
            wr_state      <= next_wr_state;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            // Each half is taken once, in either order, until the answer is gone
            s_axi_awready <= !next_aw_held && (next_wr_state == STK_CH_IDLE);
            s_axi_wready  <= !next_w_held && (next_wr_state == STK_CH_IDLE);
            s_axi_bvalid  <= (next_wr_state == STK_CH_RESP);
            if (do_write) begin
                s_axi_bresp <= (wr_sel == STK_SEL_NONE) ? `STK_RESP_SLVERR : `STK_RESP_OKAY;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awaddr_q <= 32'h0000_0000;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else begin
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control, reload and count

    assign ctrl_merged   = merge(ctrl_word, wdata_q, wstrb_q);
    assign reload_merged = merge({8'h00, reload_val}, wdata_q, wstrb_q);
    // Any write to the current value clears it, whatever the data or lanes
    assign cur_clear     = do_write && (wr_sel == STK_SEL_CURRENT);
    assign run           = enable && !core_halted;

    // A process, not a function, so every bit change re-evaluates the merge
    always_comb begin
        ctrl_word                  = 32'h0000_0000;
        ctrl_word[`STK_EN_BIT]     = enable;
        ctrl_word[`STK_IE_BIT]     = tick_irq_enable;
        ctrl_word[`STK_CLKSEL_BIT] = clock_select;
        ctrl_word[`STK_FLAG_BIT]   = wrap_flag;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable          <= `STK_BIT_RESET;
            tick_irq_enable <= `STK_BIT_RESET;
            clock_select    <= `STK_BIT_RESET;
        end else if (do_write && (wr_sel == STK_SEL_CTRL)) begin
            enable          <= ctrl_merged[`STK_EN_BIT];
            tick_irq_enable <= ctrl_merged[`STK_IE_BIT];
            // Stored and read back only; no reference clock exists here
            clock_select    <= ctrl_merged[`STK_CLKSEL_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_val <= `STK_RELOAD_RESET;
        end else if (do_write && (wr_sel == STK_SEL_RELOAD)) begin
            reload_val <= reload_merged[CNT_WIDTH-1:0];
        end
    end

    stk_down_counter #(
        .WIDTH    (CNT_WIDTH)
    ) u_counter (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (run),
        .clear    (cur_clear),
        .reload   (reload_val),
        .count    (count),
        .wrap_hit (wrap_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Wrap flag and tick exception

    // The debugger may read without disturbing the flag
    assign flag_read_clr = ar_hs && (rd_sel == STK_SEL_CTRL) &&
                           (!debugger_access || !debugger_master_kind);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrap_flag <= `STK_BIT_RESET;
        end else if (wrap_hit) begin
            // A wrap landing on the clearing read must not be lost
            wrap_flag <= 1'h1;
        end else if (flag_read_clr || cur_clear) begin
            wrap_flag <= 1'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_pend <= 1'h0;
        end else begin
            tick_pend <= wrap_hit && tick_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    assign ar_hs  = s_axi_arvalid && s_axi_arready;
    assign rd_sel = decode(s_axi_araddr);

    always_comb begin
        case (rd_sel)
            STK_SEL_CTRL:    rd_word = ctrl_word;
            STK_SEL_RELOAD:  rd_word = {8'h00, reload_val};
            STK_SEL_CURRENT: rd_word = {8'h00, count};
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_rd_state = rd_state;
        case (rd_state)
            STK_CH_IDLE: begin
                if (ar_hs) begin
                    next_rd_state = STK_CH_RESP;
                end
            end
            STK_CH_RESP: begin
                if (s_axi_rready) begin
                    next_rd_state = STK_CH_IDLE;
                end
            end
            default: begin
                next_rd_state = STK_CH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state      <= STK_CH_IDLE;
            s_axi_arready <= 1'h0;
            s_axi_rvalid  <= 1'h0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `STK_RESP_OKAY;
        end else begin
            rd_state      <= next_rd_state;
            s_axi_arready <= (next_rd_state == STK_CH_IDLE);
            s_axi_rvalid  <= (next_rd_state == STK_CH_RESP);
            if (ar_hs) begin
                // Data is frozen at acceptance, so a stalled master sees that count
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (rd_sel == STK_SEL_NONE) ? `STK_RESP_SLVERR : `STK_RESP_OKAY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_count_decrement: assert property (
        (run && !cur_clear && (count != '0)) |=> (count == $past(count) - CNT_WIDTH'(1))
    ) else $error("count did not decrement");

    chk_reload_at_zero: assert property (
        (run && !cur_clear && (count == '0)) |=> (count == $past(reload_val))
    ) else $error("count did not reload after zero");

    chk_zero_reload_parks: assert property (
        (run && !cur_clear && (count == '0) && (reload_val == '0)) |=> (count == '0)
    ) else $error("zero reload did not stop counter");

    chk_flag_on_wrap: assert property (
        (run && !cur_clear && (count == CNT_WIDTH'(1))) |=> (wrap_flag && (count == '0))
    ) else $error("wrap flag not set on reaching zero");

    chk_flag_read_clear: assert property (
        (ar_hs && (rd_sel == STK_SEL_CTRL) && !debugger_access && !wrap_hit) |=> !wrap_flag
    ) else $error("software read did not clear wrap flag");

    chk_clear_write: assert property (
        cur_clear |=> ((count == '0) && !wrap_flag && !tick_pend)
    ) else $error("current write did not clear quietly");

    chk_halt_holds: assert property (
        (core_halted && !cur_clear) |=> (count == $past(count))
    ) else $error("counter moved while core halted");

    chk_debug_read_keeps: assert property (
        (ar_hs && (rd_sel == STK_SEL_CTRL) && debugger_access && debugger_master_kind &&
         !wrap_hit && !cur_clear) |=> (wrap_flag == $past(wrap_flag))
    ) else $error("debugger read changed wrap flag");

    chk_pend_gated: assert property (
        tick_pend |-> ($past(tick_irq_enable) && wrap_flag)
    ) else $error("tick pended without enable or wrap");

    chk_disabled_still: assert property (
        (!enable && !cur_clear) |=> $stable(count)
    ) else $error("disabled counter moved");

    chk_read_reserved: assert property (
        s_axi_rvalid |-> (s_axi_rdata[31:24] == 8'h00)
    ) else $error("reserved read bits not zero");

endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ns
`include "stk_map.svh"

module tb;
    logic        clk;
    logic        rst_n;
    logic [31:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [31:0] s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        core_halted;
    logic        debugger_access;
    logic        debugger_master_kind;
    logic        tick_pend;
    int          mismatches = 0;
    int          tests_run  = 0;
    int          cyc        = 0;
    int          pend_cnt   = 0;
    int          pend_last  = 0;
    int          pend_prev  = 0;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic [1:0]  rsp;
    int          n;
    int          k;

    stk_top dut (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .core_halted(core_halted), .debugger_access(debugger_access),
        .debugger_master_kind(debugger_master_kind), .tick_pend(tick_pend)
    );

    // No reference clock is driven; the core clock alone paces the count
    always #2 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Pend pulse log: the gap between the two latest pulses gives the period
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tick_pend === 1'b1) begin
            pend_cnt  <= pend_cnt + 1;
            pend_prev <= pend_last;
            pend_last <= cyc;
        end
    end

    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic timed_out();
        mismatches++;
        finish_test();
    endtask

    task automatic check_word(input logic [31:0] e, input logic [31:0] a);
        tests_run++;
        if (a !== e) begin
            mismatches++;
            $display("Error at %0t: expected %h, got %h", $time, e, a);
        end
    endtask

    task automatic check_bool(input logic e, input logic a);
        tests_run++;
        if (a !== e) begin
            mismatches++;
            $display("Error at %0t: expected %h, got %h", $time, e, a);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus master; entered right after a rising edge
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        bit aw_d;
        bit w_d;
        bit b_d;
        aw_d = 0;
        w_d  = 0;
        b_d  = 0;
        r    = 2'h3;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (int i = 0; i < 100 && !(aw_d && w_d); i++) begin
            @(posedge clk);
            if (!aw_d && s_axi_awready === 1'b1) begin
                aw_d = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_d && s_axi_wready === 1'b1) begin
                w_d = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 100 && !b_d; i++) begin
            @(posedge clk);
            if (s_axi_bvalid === 1'b1) begin
                b_d = 1;
                r   = s_axi_bresp;
            end
        end
        s_axi_bready <= 1'b0;
        if (!(aw_d && w_d && b_d)) timed_out();
    endtask

    task automatic axi_read(input logic [31:0] a, input logic dbg, input logic kind,
                            output logic [31:0] d, output logic [1:0] r);
        bit ar_d;
        bit r_d;
        ar_d = 0;
        r_d  = 0;
        d    = 32'h0000_0000;
        r    = 2'h3;
        s_axi_araddr         <= a;
        s_axi_arvalid        <= 1'b1;
        debugger_access      <= dbg;
        debugger_master_kind <= kind;
        for (int i = 0; i < 100 && !ar_d; i++) begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) ar_d = 1;
        end
        s_axi_arvalid   <= 1'b0;
        debugger_access <= 1'b0;
        s_axi_rready    <= 1'b1;
        for (int i = 0; i < 100 && !r_d; i++) begin
            @(posedge clk);
            if (s_axi_rvalid === 1'b1) begin
                r_d = 1;
                d   = s_axi_rdata;
                r   = s_axi_rresp;
            end
        end
        s_axi_rready <= 1'b0;
        if (!(ar_d && r_d)) timed_out();
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        axi_write(a, d, 4'hF, rsp);
    endtask

    task automatic rdw(input logic [31:0] a, output logic [31:0] d);
        axi_read(a, 1'b0, 1'b0, d, rsp);
    endtask

    task automatic wait_pends(input int cnt);
        int s;
        s = pend_cnt;
        for (int i = 0; i < 3000 && pend_cnt < s + cnt; i++) @(posedge clk);
        if (pend_cnt < s + cnt) timed_out();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        rst_n = 0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h0;
        {core_halted, debugger_access, debugger_master_kind} = '0;
        void'($urandom(32'h74f4_ee51));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdw(`STK_CTRL_ADDR, rd);
        check_word(32'h0000_0000, rd);
        rdw(`STK_CURRENT_ADDR, rd);
        check_word(32'h0000_0000, rd);
        // Reserved bits drop, lanes merge little-endian
        axi_write(`STK_RELOAD_ADDR, 32'hFFFF_FFFF, 4'hF, rsp);
        check_word(`STK_RESP_OKAY, rsp);
        rdw(`STK_RELOAD_ADDR, rd);
        check_word(32'h00FF_FFFF, rd);
        axi_write(`STK_RELOAD_ADDR, 32'h0000_00AA, 4'h1, rsp);
        axi_write(`STK_RELOAD_ADDR, 32'h1234_0000, 4'h4, rsp);
        rdw(`STK_RELOAD_ADDR, rd);
        check_word(32'h0034_FFAA, rd);
        axi_write(`STK_CTRL_ADDR + 32'h0000_000C, 32'h1, 4'hF, rsp);
        check_word(`STK_RESP_SLVERR, rsp);
        axi_read(`STK_CTRL_ADDR + 32'h0000_000C, 1'b0, 1'b0, rd, rsp);
        check_word({30'h0, `STK_RESP_SLVERR}, {rd[29:0], rsp});
        // Period and pend with a reload of 2
        wr(`STK_RELOAD_ADDR, 32'h0000_0002);
        wr(`STK_CTRL_ADDR, 32'h0000_0003);
        wait_pends(3);
        check_word(32'h0000_0003, pend_last - pend_prev);
        wr(`STK_CTRL_ADDR, 32'h0000_0000);
        rdw(`STK_CTRL_ADDR, rd);
        check_word(32'h0001_0000, rd);
        rdw(`STK_CTRL_ADDR, rd);
        check_word(32'h0000_0000, rd);
        // Debugger reads: kind 1 keeps the flag, kind 0 clears it
        wr(`STK_CTRL_ADDR, 32'h0000_0007);
        wait_pends(1);
        wr(`STK_CTRL_ADDR, 32'h0000_0004);
        for (k = 0; k < 2; k++) begin
            axi_read(`STK_CTRL_ADDR, 1'b1, 1'b1, rd, rsp);
            check_word(32'h0001_0004, rd);
        end
        axi_read(`STK_CTRL_ADDR, 1'b1, 1'b0, rd, rsp);
        check_word(32'h0001_0004, rd);
        rdw(`STK_CTRL_ADDR, rd);
        check_word(32'h0000_0004, rd);
        // Upper halfword write keeps lane 0 and cannot set the flag
        axi_write(`STK_CTRL_ADDR, 32'hFFFF_FF00, 4'hC, rsp);
        rdw(`STK_CTRL_ADDR, rd);
        check_word(32'h0000_0004, rd);
        // Interrupt enable clear: flag only
        n = pend_cnt;
        wr(`STK_RELOAD_ADDR, 32'h0000_0003);
        wr(`STK_CTRL_ADDR, 32'h0000_0001);
        repeat (30) @(posedge clk);
        wr(`STK_CTRL_ADDR, 32'h0000_0000);
        check_word(n, pend_cnt);
        rdw(`STK_CTRL_ADDR, rd);
        check_word(32'h0001_0000, rd);
        // Current-value write while running with pend enabled
        wr(`STK_RELOAD_ADDR, 32'h0000_00C8);
        wr(`STK_CTRL_ADDR, 32'h0000_0003);
        repeat (5) @(posedge clk);
        n = pend_cnt;
        wr(`STK_CURRENT_ADDR, 32'h1234_5678);
        rdw(`STK_CURRENT_ADDR, rd);
        check_word(n, pend_cnt);
        check_bool(1'b1, rd > 32'h0000_00B4 && rd <= 32'h0000_00C8);
        rdw(`STK_CTRL_ADDR, rd);
        check_word(32'h0000_0003, rd);
        // Halt freezes the count; the read returns the held value
        core_halted <= 1'b1;
        rdw(`STK_CURRENT_ADDR, rd);
        repeat (10) @(posedge clk);
        rdw(`STK_CURRENT_ADDR, rd2);
        check_word(rd, rd2);
        core_halted <= 1'b0;
        repeat (10) @(posedge clk);
        rdw(`STK_CURRENT_ADDR, rd2);
        check_bool(1'b1, rd2 < rd);
        // Zero reload parks the counter at its next wrap
        wr(`STK_RELOAD_ADDR, 32'h0000_0000);
        repeat (220) @(posedge clk);
        n = pend_cnt;
        repeat (20) @(posedge clk);
        rdw(`STK_CURRENT_ADDR, rd);
        check_word(32'h0000_0000, rd);
        check_word(n, pend_cnt);
        wr(`STK_CTRL_ADDR, 32'h0000_0000);
        // Random reloads, period N+1 each time
        for (k = 0; k < 5; k++) begin
            n = 1 + ($urandom % 30);
            wr(`STK_RELOAD_ADDR, n);
            wr(`STK_CTRL_ADDR, 32'h0000_0003);
            wait_pends(2);
            check_word(n + 1, pend_last - pend_prev);
            wr(`STK_CTRL_ADDR, 32'h0000_0000);
        end
        finish_test();
    end

    initial begin
        #400000;
        timed_out();
    end
endmodule
